// File: rtl/sutrc_regs.vh
`ifndef SUTRC_REGS_VH
`define SUTRC_REGS_VH

// Register byte offsets on the Avalon-MM slave
`define SUTRC_OFF_DATA        5'h00
`define SUTRC_OFF_STATUS_A    5'h04
`define SUTRC_OFF_CONTROL_B   5'h08
`define SUTRC_OFF_FORMAT_C    5'h0C
`define SUTRC_OFF_BAUD        5'h10

// serial_status_reg_a fields
`define SUTRC_A_RXC           7
`define SUTRC_A_TXC           6
`define SUTRC_A_DATA_REGISTER_EMPTY_FLAG          5
`define SUTRC_A_U2X           1

// serial_control_reg_b fields
`define SUTRC_B_TRANSMIT_COMPLETE_IRQ_ENABLE         6
`define SUTRC_B_BUFFER_EMPTY_IRQ_ENABLE         5
`define SUTRC_B_RECEIVE_ENABLE_BIT          4
`define SUTRC_B_TRANSMIT_ENABLE_BIT          3
`define SUTRC_B_SIZE2         2
`define SUTRC_B_RXB8          1
`define SUTRC_B_TX_NINTH_BIT          0

// serial_format_reg_c fields
`define SUTRC_C_MASTER        7
`define SUTRC_C_SYNC          6
`define SUTRC_C_PEN           5
`define SUTRC_C_PODD          4
`define SUTRC_C_STOP2         3
`define SUTRC_C_SIZE_HI       2
`define SUTRC_C_SIZE_LO       1
`define SUTRC_C_POL           0

// Reset values
`define SUTRC_RST_CONTROL_B   8'h00
`define SUTRC_RST_FORMAT_C    8'h06
`define SUTRC_RST_BAUD        12'h000

// Oversampling: last sample index and majority decision index
`define SUTRC_OS_LAST_NORM    4'hF
`define SUTRC_OS_LAST_DBL     4'h7
`define SUTRC_OS_DEC_NORM     4'h9
`define SUTRC_OS_DEC_DBL      4'h5

// Character size code for nine data bits
`define SUTRC_SIZE_NINE       3'h7

`endif

// File: rtl/sutrc_core.v
// The implementer's own choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "sutrc_regs.vh"

module sutrc_core #(
    parameter DIV_W = 12
) (
    input  wire        sys_clk,
    input  wire        arst_n,
    input  wire [4:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        global_irq_enable,
    input  wire        tx_complete_irq_ack,
    output wire        irq_buffer_empty,
    output wire        irq_tx_complete,
    output wire        txd_out,
    output wire        txd_oe_n,
    input  wire        rxd_pin,
    output wire        rx_pin_owned,
    input  wire        serial_clock_pin_in,
    output wire        serial_clock_pin_out,
    output wire        serial_clock_pin_oe_n
);

    localparam [2:0] RX_IDLE  = 3'b001;
    localparam [2:0] RX_START = 3'b010;
    localparam [2:0] RX_DATA  = 3'b100;

    // Data bits for a character size code
    function [3:0] sutrc_nbits;
        input [2:0] code;
        begin
            case (code)
                3'h0:    sutrc_nbits = 4'h5;
                3'h1:    sutrc_nbits = 4'h6;
                3'h2:    sutrc_nbits = 4'h7;
                3'h7:    sutrc_nbits = 4'h9;
                default: sutrc_nbits = 4'h8;
            endcase
        end
    endfunction

    // Clear the bits above the character size
    function [8:0] sutrc_mask;
        input [8:0] d;
        input [3:0] nb;
        integer i;
        begin
            sutrc_mask = 9'h000;
            for (i = 0; i < 9; i = i + 1) begin
                if (i < nb)
                    sutrc_mask[i] = d[i];
            end
        end
    endfunction

    // Build a frame: start low, data LSB first, parity, stop high
    function [12:0] sutrc_frame;
        input [8:0] d;
        input [3:0] nb;
        input       pen;
        input       podd;
        integer i;
        reg     par;
        begin
            sutrc_frame    = 13'h1FFF;
            sutrc_frame[0] = 1'b0;
            par            = podd;
            for (i = 0; i < 9; i = i + 1) begin
                if (i < nb) begin
                    sutrc_frame[i + 1] = d[i];
                    par                = par ^ d[i];
                end
            end
            if (pen)
                sutrc_frame[nb + 4'h1] = par;
        end
    endfunction

    // Register state
    reg [7:0]       ctrl_b_reg;
    reg [7:0]       fmt_c_reg;
    reg [DIV_W-1:0] baud_reg;
    reg             u2x_reg;
    reg             bus_ack_reg;

    // Transmit state
    reg [8:0]       tx_buf_reg;
    reg             tx_full_reg;
    reg [12:0]      tx_shift_reg;
    reg [3:0]       tx_left_reg;
    reg             tx_busy_reg;
    reg             tx_active_reg;
    reg             txc_reg;
    reg [3:0]       tx_os_reg;

    // Receive state
    reg [2:0]       rx_state_reg;
    reg [3:0]       rx_os_reg;
    reg [1:0]       rx_vote_reg;
    reg [10:0]      rx_bits_reg;
    reg [3:0]       rx_idx_reg;
    reg [8:0]       rx_buf_reg;
    reg             rxc_reg;

    // Clocking and pin synchronisers
    reg [DIV_W-1:0] baud_cnt_reg;
    reg             xck_gen_reg;
    reg             xck_prev_reg;
    reg             xck_s1_reg;
    reg             xck_s2_reg;
    reg             rxd_s1_reg;
    reg             rxd_s2_reg;

    // Decoded configuration
    wire       transmit_enable_bit      = ctrl_b_reg[`SUTRC_B_TRANSMIT_ENABLE_BIT];
    wire       receive_enable_bit      = ctrl_b_reg[`SUTRC_B_RECEIVE_ENABLE_BIT];
    wire       sync_mode = fmt_c_reg[`SUTRC_C_SYNC];
    wire       master    = fmt_c_reg[`SUTRC_C_MASTER];
    wire       pen       = fmt_c_reg[`SUTRC_C_PEN];
    wire       podd      = fmt_c_reg[`SUTRC_C_PODD];
    wire       stop2     = fmt_c_reg[`SUTRC_C_STOP2];
    wire [2:0] size_code = {ctrl_b_reg[`SUTRC_B_SIZE2], fmt_c_reg[2:1]};
    wire [3:0] nbits     = sutrc_nbits(size_code);
    wire [3:0] os_last   = u2x_reg ? `SUTRC_OS_LAST_DBL : `SUTRC_OS_LAST_NORM;
    wire [3:0] os_dec    = u2x_reg ? `SUTRC_OS_DEC_DBL : `SUTRC_OS_DEC_NORM;

    // Bus handshake: one wait cycle, then commit on the released edge
    wire       bus_req   = avs_read | avs_write;
    wire       do_write  = avs_write & bus_ack_reg;
    wire       do_read   = avs_read & bus_ack_reg;
    wire [4:0] word_addr = {avs_address[4:2], 2'b00};
    assign avs_waitrequest = bus_req & ~bus_ack_reg;

    wire wr_data = do_write && (word_addr == `SUTRC_OFF_DATA);
    wire wr_stat = do_write && (word_addr == `SUTRC_OFF_STATUS_A);
    wire wr_ctrl = do_write && (word_addr == `SUTRC_OFF_CONTROL_B);
    wire rd_data = do_read && (word_addr == `SUTRC_OFF_DATA);

    // Baud tick: one per (divisor + 1) system clocks
    wire tick = (baud_cnt_reg == {DIV_W{1'b0}});

    // Serial clock level is our divider as master, the synced pin as slave
    wire xck_level   = master ? xck_gen_reg : xck_s2_reg;
    wire xck_rise    = xck_level & ~xck_prev_reg;
    wire xck_fall    = ~xck_level & xck_prev_reg;
    wire pol         = fmt_c_reg[`SUTRC_C_POL];
    wire tx_sync_evt = pol ? xck_fall : xck_rise;
    wire rx_sync_evt = pol ? xck_rise : xck_fall;

    // Transmit bit boundary
    wire tx_bit_evt = sync_mode ? tx_sync_evt
                                : (tick && tx_os_reg == os_last);
    wire tx_frame_end = tx_busy_reg && tx_bit_evt && tx_left_reg == 4'h1;
    wire tx_load_idle = !tx_busy_reg && tx_full_reg && tx_active_reg &&
                        (!sync_mode || tx_sync_evt);
    wire tx_load      = tx_load_idle || (tx_frame_end && tx_full_reg && tx_active_reg);
    wire [12:0] tx_frame_new = sutrc_frame(tx_buf_reg, nbits, pen, podd);
    wire [3:0]  tx_len_new   = 4'h2 + nbits + {3'h0, pen} + {3'h0, stop2};

    // Receive bit decision and majority vote
    wire rxd    = rxd_s2_reg;
    wire rx_maj = (rx_vote_reg[1] & rx_vote_reg[0]) | (rx_vote_reg[1] & rxd) |
                  (rx_vote_reg[0] & rxd);
    wire rx_dec = sync_mode ? rx_sync_evt : (tick && rx_os_reg == os_dec);
    wire rx_bit = sync_mode ? rxd : rx_maj;
    wire [3:0] rx_total = nbits + {3'h0, pen} + 4'h1;
    wire rx_store = receive_enable_bit && (rx_state_reg == RX_DATA) && rx_dec &&
                    (rx_idx_reg == rx_total - 4'h1);

    // Pin ownership and interrupt levels
    assign txd_out   = tx_shift_reg[0];
    assign txd_oe_n  = ~tx_active_reg;
    assign rx_pin_owned = receive_enable_bit;
    assign serial_clock_pin_out  = xck_gen_reg;
    assign serial_clock_pin_oe_n = ~(sync_mode & master & (tx_active_reg | receive_enable_bit));
    assign irq_buffer_empty = global_irq_enable & ctrl_b_reg[`SUTRC_B_BUFFER_EMPTY_IRQ_ENABLE] &
                              ~tx_full_reg;
    assign irq_tx_complete  = global_irq_enable & ctrl_b_reg[`SUTRC_B_TRANSMIT_COMPLETE_IRQ_ENABLE] &
                              txc_reg;

    // Bus acknowledge and registered read data
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_ack_reg  <= 1'b0;
            avs_readdata <= 32'h0000_0000;
        end else begin
            bus_ack_reg <= bus_req & ~bus_ack_reg;
            if (avs_read && !bus_ack_reg) begin
                case (word_addr)
                    `SUTRC_OFF_DATA:
                        avs_readdata <= {24'h000000, rx_buf_reg[7:0]};
                    `SUTRC_OFF_STATUS_A:
                        avs_readdata <= {24'h000000, rxc_reg, txc_reg, ~tx_full_reg,
                                         3'h0, u2x_reg, 1'b0};
                    `SUTRC_OFF_CONTROL_B:
                        avs_readdata <= {24'h000000, ctrl_b_reg[7:2], rx_buf_reg[8],
                                         ctrl_b_reg[0]};
                    `SUTRC_OFF_FORMAT_C:
                        avs_readdata <= {24'h000000, fmt_c_reg};
                    `SUTRC_OFF_BAUD:
                        avs_readdata <= {{(32-DIV_W){1'b0}}, baud_reg};
                    default:
                        avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration registers
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_b_reg <= `SUTRC_RST_CONTROL_B;
            fmt_c_reg  <= `SUTRC_RST_FORMAT_C;
            baud_reg   <= `SUTRC_RST_BAUD;
            u2x_reg    <= 1'b0;
        end else begin
            if (wr_ctrl)
                ctrl_b_reg <= {1'b0, avs_writedata[6:2], 1'b0, avs_writedata[0]};
            if (do_write && word_addr == `SUTRC_OFF_FORMAT_C)
                fmt_c_reg <= avs_writedata[7:0];
            if (do_write && word_addr == `SUTRC_OFF_BAUD)
                baud_reg <= avs_writedata[DIV_W-1:0];
            if (wr_stat)
                u2x_reg <= avs_writedata[`SUTRC_A_U2X];
        end
    end

    // Baud divider and master serial clock
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            baud_cnt_reg <= {DIV_W{1'b0}};
            xck_gen_reg  <= 1'b0;
        end else begin
            if (tick)
                baud_cnt_reg <= baud_reg;
            else
                baud_cnt_reg <= baud_cnt_reg - {{(DIV_W-1){1'b0}}, 1'b1};
            if (tick && sync_mode && master)
                xck_gen_reg <= ~xck_gen_reg;
            else if (!sync_mode || !master)
                xck_gen_reg <= 1'b0;
        end
    end

    // Pin synchronisers and serial clock edge history
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            xck_s1_reg   <= 1'b0;
            xck_s2_reg   <= 1'b0;
            xck_prev_reg <= 1'b0;
            rxd_s1_reg   <= 1'b1;
            rxd_s2_reg   <= 1'b1;
        end else begin
            xck_s1_reg   <= serial_clock_pin_in;
            xck_s2_reg   <= xck_s1_reg;
            xck_prev_reg <= xck_level;
            rxd_s1_reg   <= rxd_pin;
            rxd_s2_reg   <= rxd_s1_reg;
        end
    end

    // Transmit buffer, empty flag and complete flag
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_buf_reg  <= 9'h000;
            tx_full_reg <= 1'b0;
            txc_reg     <= 1'b0;
        end else begin
            if (wr_data) begin
                tx_buf_reg  <= sutrc_mask({ctrl_b_reg[`SUTRC_B_TX_NINTH_BIT],
                                           avs_writedata[7:0]}, nbits);
                tx_full_reg <= 1'b1;
            end else if (tx_load) begin
                tx_full_reg <= 1'b0;
            end
            if (tx_frame_end && !(tx_full_reg && tx_active_reg))
                txc_reg <= 1'b1;
            else if (tx_complete_irq_ack || (wr_stat && avs_writedata[`SUTRC_A_TXC]))
                txc_reg <= 1'b0;
        end
    end

    // Transmit shifter and enable hold-off
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_shift_reg  <= 13'h1FFF;
            tx_left_reg   <= 4'h0;
            tx_busy_reg   <= 1'b0;
            tx_active_reg <= 1'b0;
            tx_os_reg     <= 4'h0;
        end else begin
            tx_active_reg <= transmit_enable_bit | (tx_active_reg & (tx_busy_reg | tx_full_reg));
            if (tx_load) begin
                tx_shift_reg <= tx_frame_new;
                tx_left_reg  <= tx_len_new;
                tx_busy_reg  <= 1'b1;
                tx_os_reg    <= 4'h0;
            end else begin
                if (tick)
                    tx_os_reg <= (tx_os_reg == os_last) ? 4'h0 : tx_os_reg + 4'h1;
                if (tx_frame_end) begin
                    tx_busy_reg  <= 1'b0;
                    tx_shift_reg <= 13'h1FFF;
                    tx_left_reg  <= 4'h0;
                end else if (tx_busy_reg && tx_bit_evt) begin
                    tx_shift_reg <= {1'b1, tx_shift_reg[12:1]};
                    tx_left_reg  <= tx_left_reg - 4'h1;
                end
            end
        end
    end

    // Receiver frame engine
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_state_reg <= RX_IDLE;
            rx_os_reg    <= 4'h0;
            rx_vote_reg  <= 2'b11;
            rx_bits_reg  <= 11'h000;
            rx_idx_reg   <= 4'h0;
        end else if (!receive_enable_bit) begin
            rx_state_reg <= RX_IDLE;
            rx_os_reg    <= 4'h0;
            rx_idx_reg   <= 4'h0;
        end else begin
            if (tick) begin
                rx_vote_reg <= {rx_vote_reg[0], rxd};
                rx_os_reg   <= (rx_os_reg == os_last) ? 4'h0 : rx_os_reg + 4'h1;
            end
            case (rx_state_reg)
                RX_IDLE: begin
                    if (sync_mode && rx_sync_evt && !rxd) begin
                        rx_state_reg <= RX_DATA;
                        rx_idx_reg   <= 4'h0;
                    end else if (!sync_mode && tick && !rxd) begin
                        rx_state_reg <= RX_START;
                        rx_os_reg    <= 4'h1;
                    end
                end
                RX_START: begin
                    if (rx_dec) begin
                        rx_idx_reg   <= 4'h0;
                        rx_state_reg <= rx_bit ? RX_IDLE : RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (rx_dec) begin
                        rx_bits_reg[rx_idx_reg] <= rx_bit;
                        rx_idx_reg <= rx_idx_reg + 4'h1;
                        if (rx_store)
                            rx_state_reg <= RX_IDLE;
                    end
                end
                default: begin
                    rx_state_reg <= RX_IDLE;
                end
            endcase
        end
    end

    // Receive buffer and receive-complete flag
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            rx_buf_reg <= 9'h000;
            rxc_reg    <= 1'b0;
        end else if (!receive_enable_bit) begin
            rx_buf_reg <= 9'h000;
            rxc_reg    <= 1'b0;
        end else if (rx_store) begin
            rx_buf_reg <= sutrc_mask(rx_bits_reg[8:0], nbits);
            rxc_reg    <= 1'b1;
        end else if (rd_data) begin
            rxc_reg    <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// File: testbench/sutrc_props.sv
`timescale 1ns/1ps
`default_nettype none
module sutrc_props #(
    parameter DIV_W = 12
) (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    input wire logic        global_irq_enable,
    input wire logic        tx_complete_irq_ack,
    input wire logic        irq_buffer_empty,
    input wire logic        irq_tx_complete,
    input wire logic        txd_out,
    input wire logic        txd_oe_n,
    input wire logic        rx_pin_owned
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // Writes that commit at this edge, per register word
    wire logic wr_data = avs_write & ~avs_waitrequest & (avs_address[4:2] == 3'h0);
    wire logic wr_ctrl = avs_write & ~avs_waitrequest & (avs_address[4:2] == 3'h2);
    // Pin ownership follows the enable bits
    property p_tx_own; wr_ctrl && avs_writedata[3] |-> ##2 !txd_oe_n; endproperty
    a_tx_own: assert property (p_tx_own) else $error("tx pin not taken");
    property p_rx_own; wr_ctrl |=> rx_pin_owned == $past(avs_writedata[4]); endproperty
    a_rx_own: assert property (p_rx_own) else $error("rx pin ownership wrong");
    // Flags and interrupt requests
    property p_clr_empty; wr_data |=> !irq_buffer_empty; endproperty
    a_clr_empty: assert property (p_clr_empty) else $error("empty kept after write");
    property p_be_gie; irq_buffer_empty |-> global_irq_enable; endproperty
    a_be_gie: assert property (p_be_gie) else $error("empty irq while masked");
    property p_tc_gie; irq_tx_complete |-> global_irq_enable; endproperty
    a_tc_gie: assert property (p_tc_gie) else $error("complete irq while masked");
    property p_ack; tx_complete_irq_ack |=> !irq_tx_complete; endproperty
    a_ack: assert property (p_ack) else $error("complete kept after service");
    // Line framing and release, data read upper bits
    property p_start; $fell(txd_out) |-> (!txd_out && !txd_oe_n) [*8]; endproperty
    a_start: assert property (p_start) else $error("low bit too short");
    property p_release; $rose(txd_oe_n) |-> txd_out && $past(txd_out); endproperty
    a_release: assert property (p_release) else $error("pin released mid frame");
    property p_idle; txd_oe_n |-> txd_out; endproperty
    a_idle: assert property (p_idle) else $error("released line not high");
    property p_rd_zero;
        avs_read && !avs_waitrequest && avs_address[4:2] == 3'h0 |-> avs_readdata[31:8] == 24'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("data read upper bits set");
endmodule
bind sutrc_core sutrc_props #(.DIV_W(DIV_W)) u_props (
    .sys_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_readdata, .avs_waitrequest, .global_irq_enable, .tx_complete_irq_ack,
    .irq_buffer_empty, .irq_tx_complete, .txd_out, .txd_oe_n, .rx_pin_owned
);
`default_nettype wire

// File: testbench/sutrc_partner.sv
`timescale 1ns/1ps
`default_nettype none
module sutrc_partner (
    input  wire logic       clk,
    input  wire logic       line_in,
    input  wire logic [4:0] per,
    input  wire logic [3:0] nb,
    input  wire logic       pen,
    input  wire logic       podd,
    output var  logic       line_out,
    output var  logic [8:0] got,
    output var  logic       got_par,
    output var  logic [7:0] got_cnt
);
    logic [8:0] v;
    int         i;
    // Monitor: sample each bit of a frame at its middle
    initial begin
        line_out = 1'b1;
        got_cnt = 8'h00;
        forever begin
            @(posedge clk);
            if (line_in === 1'b0) begin
                repeat (per / 2) @(posedge clk);
                v = 9'h000;
                for (i = 0; i < nb; i++) begin
                    repeat (per) @(posedge clk);
                    v[i] = line_in;
                end
                repeat (per) @(posedge clk);
                got_par = line_in;
                if (pen) repeat (per) @(posedge clk);
                got = v;
                got_cnt = got_cnt + 8'h01;
            end
        end
    end
    // Sender: start low, data LSB first, parity, one high stop
    task automatic send(input logic [8:0] d);
        int k;
        begin
            @(posedge clk);
            line_out <= 1'b0;
            for (k = 0; k < nb; k++) begin
                repeat (per) @(posedge clk);
                line_out <= d[k];
            end
            if (pen) begin
                repeat (per) @(posedge clk);
                line_out <= ^d ^ podd;
            end
            repeat (per) @(posedge clk);
            line_out <= 1'b1;
            repeat (per) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// File: testbench/test_serial_usart_tx_rx_core.sv
`timescale 1ns/1ps
`default_nettype none
module test_serial_usart_tx_rx_core;
    logic        sys_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic        global_irq_enable = 1'b1;
    logic        tx_complete_irq_ack = 1'b0;
    logic [4:0]  per = 5'h10;
    logic [3:0]  nb = 4'h8;
    logic        pen = 1'b0;
    logic        podd = 1'b0;
    logic [31:0] q;
    wire  [31:0] avs_readdata;
    wire         avs_waitrequest, irq_buffer_empty, irq_tx_complete;
    wire         txd_out, txd_oe_n, rx_pin_owned, rxd_pin, got_par;
    wire         xck_out, xck_oe_n;
    wire  [8:0]  got;
    wire  [7:0]  got_cnt;
    int          failures = 0;
    int          cmp_count = 0;
    // Frame table: size code, {parity, odd, two stops, double speed}, data
    logic [2:0]  szt [5] = '{3'h3, 3'h0, 3'h2, 3'h7, 3'h1};
    logic [3:0]  opt [5] = '{4'h0, 4'h2, 4'h8, 4'hC, 4'hF};
    logic [8:0]  dt  [5] = '{9'h0A5, 9'h0FF, 9'h05A, 9'h13C, 9'h0E7};
    // Released transmit pin is pulled up
    wire         txd_line = txd_oe_n ? 1'b1 : txd_out;
    always #10 sys_clk = ~sys_clk;
    sutrc_core #(.DIV_W(12)) uut (
        .sys_clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest, .global_irq_enable, .tx_complete_irq_ack,
        .irq_buffer_empty, .irq_tx_complete, .txd_out, .txd_oe_n, .rxd_pin,
        .rx_pin_owned, .serial_clock_pin_in(1'b0), .serial_clock_pin_out(xck_out),
        .serial_clock_pin_oe_n(xck_oe_n)
    );
    sutrc_partner u_partner (
        .clk(sys_clk), .line_in(txd_line), .per, .nb, .pen, .podd,
        .line_out(rxd_pin), .got, .got_par, .got_cnt
    );
    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chkb(input string n, input logic e, input logic g);
        chk(n, {31'h0, e}, {31'h0, g});
    endtask
    task automatic stall(input string n);
        failures++;
        $display("MISMATCH %s expected done seen timeout", n);
        end_sim;
    endtask
    // One Avalon access; read data lands in q
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int i;
        begin
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= w;
            avs_read <= ~w;
            i = 0;
            do begin
                @(posedge sys_clk);
                if (++i > 20) stall("waitrequest");
            end while (avs_waitrequest !== 1'b0);
            q = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge sys_clk);
        end
    endtask
    task automatic wait_frame(input logic [7:0] n);
        int i;
        begin
            i = 0;
            while (got_cnt !== n) begin
                if (++i > 4000) stall("frame");
                @(posedge sys_clk);
            end
        end
    endtask
    task automatic wait_st(input int b, input logic v);
        int i;
        begin
            i = 0;
            do begin
                bus(1'b0, 5'h04, 32'h0);
                if (++i > 300) stall("status");
            end while (q[b] !== v);
        end
    endtask
    initial begin
        int k;
        logic [2:0] s;
        logic [3:0] o;
        logic [3:0] n;
        logic [8:0] e;
        logic [7:0] c;
        repeat (3) @(posedge sys_clk);
        arst_n <= 1'b1;
        @(posedge sys_clk);
        bus(1'b0, 5'h04, 32'h0);
        chk("status reset", 32'h20, q);
        bus(1'b0, 5'h0C, 32'h0);
        chk("format reset", 32'h06, q);
        bus(1'b1, 5'h14, 32'hFF);
        bus(1'b0, 5'h14, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'b1, 5'h10, 32'h0);
        // Every size and parity mode, both directions
        for (k = 0; k < 5; k++) begin
            s = szt[k];
            o = opt[k];
            n = (s == 3'h7) ? 4'h9 : 4'h5 + {1'b0, s};
            e = dt[k] & ~(9'h1FF << n);
            nb <= n;
            pen <= o[3];
            podd <= o[2];
            per <= o[0] ? 5'h08 : 5'h10;
            bus(1'b1, 5'h0C, {26'h0, o[3:1], s[1:0], 1'b0});
            bus(1'b1, 5'h04, {30'h0, o[0], 1'b0});
            bus(1'b1, 5'h08, {24'h0, 5'h0F, s[2], 1'b0, dt[k][8]});
            c = got_cnt;
            bus(1'b1, 5'h00, {24'h0, dt[k][7:0]});
            wait_frame(c + 8'h01);
            chk("tx data", {23'h0, e}, {23'h0, got});
            if (o[3]) chkb("tx parity", ^e ^ o[2], got_par);
            u_partner.send(e);
            wait_st(7, 1'b1);
            bus(1'b0, 5'h08, 32'h0);
            chkb("rx ninth", e[8], q[1]);
            bus(1'b0, 5'h00, 32'h0);
            chk("rx data", {24'h0, e[7:0]}, q);
        end
        nb <= 4'h8;
        pen <= 1'b0;
        per <= 5'h10;
        bus(1'b1, 5'h0C, 32'h06);
        bus(1'b1, 5'h08, 32'h78);
        bus(1'b1, 5'h04, 32'h40);
        bus(1'b0, 5'h04, 32'h0);
        chkb("complete cleared", 1'b0, q[6]);
        // Back-to-back characters
        c = got_cnt;
        bus(1'b1, 5'h00, 32'hC3);
        bus(1'b1, 5'h00, 32'h3C);
        bus(1'b0, 5'h04, 32'h0);
        chk("flags full", 32'h0, q & 32'hE0);
        chkb("empty irq", 1'b0, irq_buffer_empty);
        wait_frame(c + 8'h01);
        chk("first", 32'hC3, {23'h0, got});
        bus(1'b0, 5'h04, 32'h0);
        chkb("complete early", 1'b0, q[6]);
        wait_frame(c + 8'h02);
        chk("second", 32'h3C, {23'h0, got});
        wait_st(6, 1'b1);
        chkb("complete irq", 1'b1, irq_tx_complete);
        chkb("empty irq", 1'b1, irq_buffer_empty);
        global_irq_enable <= 1'b0;
        @(negedge sys_clk);
        chkb("masked complete", 1'b0, irq_tx_complete);
        chkb("masked empty", 1'b0, irq_buffer_empty);
        @(posedge sys_clk);
        global_irq_enable <= 1'b1;
        tx_complete_irq_ack <= 1'b1;
        @(posedge sys_clk);
        tx_complete_irq_ack <= 1'b0;
        @(negedge sys_clk);
        chkb("serviced", 1'b0, irq_tx_complete);
        @(posedge sys_clk);
        // Disable in mid frame
        c = got_cnt;
        bus(1'b1, 5'h00, 32'h96);
        bus(1'b1, 5'h08, 32'h70);
        chkb("still owned", 1'b0, txd_oe_n);
        wait_frame(c + 8'h01);
        chk("last frame", 32'h96, {23'h0, got});
        wait_st(6, 1'b1);
        chkb("released", 1'b1, txd_oe_n);
        // Receiver disable flushes buffer
        u_partner.send(9'h055);
        wait_st(7, 1'b1);
        chkb("rx owned", 1'b1, rx_pin_owned);
        bus(1'b1, 5'h08, 32'h0);
        bus(1'b0, 5'h04, 32'h0);
        chkb("flushed", 1'b0, q[7]);
        chkb("rx released", 1'b0, rx_pin_owned);
        // Synchronous master: one bit per two divider ticks
        chk("clock pin idle", 32'h2, {30'h0, xck_oe_n, xck_out});
        per <= 5'h08;
        bus(1'b1, 5'h10, 32'h3);
        bus(1'b1, 5'h0C, 32'hC6);
        bus(1'b1, 5'h08, 32'h78);
        c = got_cnt;
        bus(1'b1, 5'h00, 32'h5A);
        chkb("clock pin owned", 1'b0, xck_oe_n);
        wait_frame(c + 8'h01);
        chk("sync data", 32'h5A, {23'h0, got});
        end_sim;
    end
endmodule
`default_nettype wire
